// *** design/erc_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module erc_top (
	// Clock and power-on reset
	input  wire logic                   clk_in,
	input  wire logic                   rst_in,
	// AHB-Lite slave
	input  wire logic                   hsel_in,
	input  wire logic [31:0]            haddr_in,
	input  wire logic [1:0]             htrans_in,
	input  wire logic                   hwrite_in,
	input  wire logic [2:0]             hsize_in,
	input  wire logic [31:0]            hwdata_in,
	input  wire logic                   hready_in,
	output logic      [31:0]            hrdata_out,
	output logic                        hreadyout_out,
	output logic                        hresp_out,
	// Chip context and analog sense
	input  wire erc_pkg::erc_mode_type  chip_mode_in,
	input  wire logic                   main_supply_on_in,
	input  wire erc_pkg::erc_sense_type sense_in,
	// Regulator drive
	output erc_pkg::erc_drive_type      drive_out,
	output logic                        soft_reset_out
);

	////////////////////////////////////////////////////////////////////////////
	// Bus address phase capture

	logic        wr_pend;
	logic        rd_pend;
	logic [7:0]  addr_q;
	logic        next_wr_pend;
	logic        next_rd_pend;
	logic [7:0]  next_addr_q;
	logic        take;

	always_comb begin
		take         = hsel_in && hready_in && (htrans_in == erc_pkg::HTRANS_NONSEQ);
		next_wr_pend = take && hwrite_in;
		next_rd_pend = take && !hwrite_in;
		next_addr_q  = take ? haddr_in[7:0] : addr_q;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q  <= 8'h00;
		end else begin
			wr_pend <= next_wr_pend;
			rd_pend <= next_rd_pend;
			addr_q  <= next_addr_q;
		end
	end

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Sense synchronisers

	erc_pkg::erc_sense_type sense_s1;
	erc_pkg::erc_sense_type sense_s2;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sense_s1 <= '0;
			sense_s2 <= '0;
		end else begin
			sense_s1 <= sense_in;
			sense_s2 <= sense_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration, control and flags

	erc_pkg::erc_cfg_type cfg;
	erc_pkg::erc_cfg_type next_cfg;
	logic on_bit, vsel, keep_on, ls_sel, ls_stop;
	logic next_on_bit, next_vsel, next_keep_on, next_ls_sel, next_ls_stop;
	logic oc_flag, uv_flag, fail_flag, soft_pulse;
	logic next_oc_flag, next_uv_flag, next_fail_flag, next_soft_pulse;

	logic        wr_ctrl, wr_hw, wr_stat;
	logic [31:0] wd;
	logic        is_normal;

	always_comb begin
		wr_ctrl         = wr_pend && hit(addr_q, erc_pkg::CTRL_OFFSET);
		wr_hw           = wr_pend && hit(addr_q, erc_pkg::HWCTRL_OFFSET);
		wr_stat         = wr_pend && hit(addr_q, erc_pkg::STAT_OFFSET);
		wd              = hwdata_in;
		is_normal       = (chip_mode_in == erc_pkg::ERC_MODE_NORMAL);
		next_cfg        = cfg;
		next_on_bit     = on_bit;
		next_vsel       = vsel;
		next_keep_on    = keep_on;
		next_ls_sel     = ls_sel;
		next_ls_stop    = ls_stop;
		next_fail_flag  = fail_flag;
		next_soft_pulse = wr_ctrl && wd[erc_pkg::CTRL_SOFTRST_BIT];
		// Soft reset drops switch and options but never the lock
		if (soft_pulse) begin
			next_on_bit  = 1'b0;
			next_keep_on = 1'b0;
			next_ls_stop = 1'b0;
		end
		if (wr_ctrl) begin
			next_vsel    = wd[erc_pkg::CTRL_VSEL_BIT];
			next_keep_on = wd[erc_pkg::CTRL_KEEPON_BIT];
			unique case (cfg)
				erc_pkg::ERC_CFG_NONE: begin
					if (wd[erc_pkg::CTRL_ON_BIT] && is_normal) begin
						next_cfg    = erc_pkg::ERC_CFG_STANDALONE;
						next_on_bit = 1'b1;
					end
				end
				erc_pkg::ERC_CFG_STANDALONE: begin
					next_on_bit = wd[erc_pkg::CTRL_ON_BIT];
				end
				erc_pkg::ERC_CFG_LOADSHARE: begin
					if (wd[erc_pkg::CTRL_ON_BIT])
						next_fail_flag = 1'b1;
				end
				default: next_cfg = erc_pkg::ERC_CFG_NONE;
			endcase
		end
		if (wr_hw) begin
			next_ls_stop = wd[erc_pkg::HW_LSSTOP_BIT];
			unique case (cfg)
				erc_pkg::ERC_CFG_NONE: begin
					// Load sharing must be set up where the main supply is fully active
					if (wd[erc_pkg::HW_LS_BIT] && is_normal) begin
						next_cfg    = erc_pkg::ERC_CFG_LOADSHARE;
						next_ls_sel = 1'b1;
					end
				end
				erc_pkg::ERC_CFG_STANDALONE: begin
					// Refused silently in stand-alone
					next_ls_sel = 1'b0;
				end
				erc_pkg::ERC_CFG_LOADSHARE: begin
					if (!wd[erc_pkg::HW_LS_BIT])
						next_fail_flag = 1'b1;
				end
				default: next_cfg = erc_pkg::ERC_CFG_NONE;
			endcase
		end
		// Overcurrent: set wins; clear only once condition gone
		next_oc_flag = oc_flag;
		if (wr_stat && wd[erc_pkg::ST_OC_BIT] && !sense_s2.overcurrent)
			next_oc_flag = 1'b0;
		if (cfg == erc_pkg::ERC_CFG_STANDALONE && sense_s2.overcurrent)
			next_oc_flag = 1'b1;
		next_uv_flag = uv_flag;
		if (wr_stat && wd[erc_pkg::ST_UV_BIT])
			next_uv_flag = 1'b0;
		if (cfg == erc_pkg::ERC_CFG_STANDALONE && sense_s2.ext_undervoltage)
			next_uv_flag = 1'b1;
		if (wr_stat && wd[erc_pkg::ST_CMDFAIL_BIT] && !(next_fail_flag && !fail_flag))
			next_fail_flag = 1'b0;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cfg        <= erc_pkg::ERC_CFG_NONE;
			on_bit     <= 1'b0;
			vsel       <= 1'b0;
			keep_on    <= 1'b0;
			ls_sel     <= 1'b0;
			ls_stop    <= 1'b0;
			oc_flag    <= 1'b0;
			uv_flag    <= 1'b0;
			fail_flag  <= 1'b0;
			soft_pulse <= 1'b0;
		end else begin
			cfg        <= next_cfg;
			on_bit     <= next_on_bit;
			vsel       <= next_vsel;
			keep_on    <= next_keep_on;
			ls_sel     <= next_ls_sel;
			ls_stop    <= next_ls_stop;
			oc_flag    <= next_oc_flag;
			uv_flag    <= next_uv_flag;
			fail_flag  <= next_fail_flag;
			soft_pulse <= next_soft_pulse;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Regulator state by chip mode

	logic                  sa_hold;
	logic                  next_sa_hold;
	erc_pkg::erc_drive_type drive;
	erc_pkg::erc_drive_type next_drive;
	logic                  want;
	logic                  uv_block;

	always_comb begin
		// Stand-alone state freezes at the value held when normal mode was left
		next_sa_hold = is_normal ? on_bit : sa_hold;
		want         = 1'b0;
		unique case (chip_mode_in)
			erc_pkg::ERC_MODE_NORMAL:
				want = (cfg == erc_pkg::ERC_CFG_STANDALONE) ? on_bit
				     : (cfg == erc_pkg::ERC_CFG_LOADSHARE) && ls_sel;
			erc_pkg::ERC_MODE_STOP:
				want = (cfg == erc_pkg::ERC_CFG_STANDALONE) ? sa_hold
				     : (cfg == erc_pkg::ERC_CFG_LOADSHARE) && ls_sel && ls_stop;
			erc_pkg::ERC_MODE_SLEEP,
			erc_pkg::ERC_MODE_RESTART:
				want = (cfg == erc_pkg::ERC_CFG_STANDALONE) ? sa_hold
				     : (cfg == erc_pkg::ERC_CFG_LOADSHARE) && ls_sel
				       && chip_mode_in == erc_pkg::ERC_MODE_RESTART
				       && main_supply_on_in;
			default: want = 1'b0;
		endcase
		// Off on low supply unless overridden; returns by itself
		uv_block              = sense_s2.supply_low && !keep_on;
		next_drive.enable     = want && !uv_block;
		next_drive.select_1v8 = (cfg == erc_pkg::ERC_CFG_STANDALONE) && vsel;
		next_drive.high_power_path = next_drive.enable;
		next_drive.low_power_path  = next_drive.enable && !is_normal;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sa_hold <= 1'b0;
			drive   <= '0;
		end else begin
			sa_hold <= next_sa_hold;
			drive   <= next_drive;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data and outputs

	logic [31:0] rdata;
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = erc_pkg::RESET_WORD;
		if (next_rd_pend) begin
			if (hit(haddr_in[7:0], erc_pkg::CTRL_OFFSET)) begin
				next_rdata[erc_pkg::CTRL_ON_BIT]     = on_bit;
				next_rdata[erc_pkg::CTRL_VSEL_BIT]   = vsel;
				next_rdata[erc_pkg::CTRL_KEEPON_BIT] = keep_on;
			end else if (hit(haddr_in[7:0], erc_pkg::HWCTRL_OFFSET)) begin
				next_rdata[erc_pkg::HW_LS_BIT]     = ls_sel;
				next_rdata[erc_pkg::HW_LSSTOP_BIT] = ls_stop;
			end else if (hit(haddr_in[7:0], erc_pkg::STAT_OFFSET)) begin
				next_rdata[erc_pkg::ST_ENABLED_BIT] = drive.enable;
				next_rdata[erc_pkg::ST_VSEL_BIT]    = drive.select_1v8;
				next_rdata[erc_pkg::ST_LOCKED_BIT]  = (cfg != erc_pkg::ERC_CFG_NONE);
				next_rdata[erc_pkg::ST_LSCFG_BIT]   = (cfg == erc_pkg::ERC_CFG_LOADSHARE);
				next_rdata[erc_pkg::ST_OC_BIT]      = oc_flag;
				next_rdata[erc_pkg::ST_UV_BIT]      = uv_flag;
				next_rdata[erc_pkg::ST_CMDFAIL_BIT] = fail_flag;
				next_rdata[erc_pkg::ST_HPPATH_BIT]  = drive.high_power_path;
			end else if (hit(haddr_in[7:0], erc_pkg::MODE_OFFSET)) begin
				next_rdata[2:0] = chip_mode_in;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			rdata <= erc_pkg::RESET_WORD;
		else
			rdata <= next_rdata;
	end

	assign hrdata_out     = rdata;
	assign hreadyout_out  = 1'b1;
	assign hresp_out      = 1'b0;
	assign drive_out      = drive;
	assign soft_reset_out = soft_pulse;

endmodule // erc_top

`default_nettype wire

// *** common/erc_pkg.sv ***
package erc_pkg;

	// Register byte offsets (word aligned)
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] HWCTRL_OFFSET = 8'h04;
	localparam logic [7:0] STAT_OFFSET   = 8'h08;
	localparam logic [7:0] MODE_OFFSET   = 8'h0c;

	// Control register fields
	localparam int CTRL_ON_BIT     = 0;
	localparam int CTRL_VSEL_BIT   = 1;
	localparam int CTRL_KEEPON_BIT = 2;
	localparam int CTRL_SOFTRST_BIT = 3;
	// Hardware control register fields
	localparam int HW_LS_BIT       = 0;
	localparam int HW_LSSTOP_BIT   = 1;
	// Status register fields (write 1 clears flags)
	localparam int ST_ENABLED_BIT  = 0;
	localparam int ST_VSEL_BIT     = 1;
	localparam int ST_LOCKED_BIT   = 2;
	localparam int ST_LSCFG_BIT    = 3;
	localparam int ST_OC_BIT       = 4;
	localparam int ST_UV_BIT       = 5;
	localparam int ST_CMDFAIL_BIT  = 6;
	localparam int ST_HPPATH_BIT   = 7;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [31:0] RESET_WORD   = 32'h0000_0000;

	typedef enum logic [2:0] {
		ERC_MODE_INIT,
		ERC_MODE_NORMAL,
		ERC_MODE_STOP,
		ERC_MODE_SLEEP,
		ERC_MODE_RESTART,
		ERC_MODE_FAILSAFE
	} erc_mode_type;

	typedef enum logic [1:0] {
		ERC_CFG_NONE,
		ERC_CFG_STANDALONE,
		ERC_CFG_LOADSHARE
	} erc_cfg_type;

	// Analog sense inputs, asynchronous to clk_in
	typedef struct packed {
		logic supply_low;
		logic overcurrent;
		logic ext_undervoltage;
	} erc_sense_type;

	// Regulator drive towards the analog section
	typedef struct packed {
		logic enable;
		logic select_1v8;
		logic high_power_path;
		logic low_power_path;
	} erc_drive_type;

endpackage

// *** sim/erc_load_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pass transistor and supply sense stand-in; faults appear only on bench request
module erc_load_model (
	// Clock and bench requests
	input  wire logic                   clk_in,
	input  wire logic                   low_req_in,
	input  wire logic                   oc_req_in,
	input  wire logic                   uv_req_in,
	// Regulator side
	input  wire erc_pkg::erc_drive_type drive_in,
	output var  erc_pkg::erc_sense_type sense_out
);
	// Shunt limit and output sag only exist while the transistor conducts
	always @(posedge clk_in) begin
		sense_out.supply_low       <= low_req_in;
		sense_out.overcurrent      <= oc_req_in && drive_in.enable;
		sense_out.ext_undervoltage <= uv_req_in && drive_in.enable;
	end
endmodule // erc_load_model
`default_nettype wire

// *** sim/erc_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module erc_top_assertions (
	// Bus side
	input wire logic                   clk_in,
	input wire logic                   rst_in,
	input wire logic                   hsel_in,
	input wire logic [31:0]            haddr_in,
	input wire logic [1:0]             htrans_in,
	input wire logic                   hwrite_in,
	input wire logic [2:0]             hsize_in,
	input wire logic [31:0]            hwdata_in,
	input wire logic                   hready_in,
	input wire logic [31:0]            hrdata_out,
	input wire logic                   hreadyout_out,
	input wire logic                   hresp_out,
	// Chip context and regulator
	input wire erc_pkg::erc_mode_type  chip_mode_in,
	input wire logic                   main_supply_on_in,
	input wire erc_pkg::erc_sense_type sense_in,
	input wire erc_pkg::erc_drive_type drive_out,
	input wire logic                   soft_reset_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic rd_req;
	assign rd_req = hsel_in && hready_in && htrans_in == erc_pkg::HTRANS_NONSEQ && !hwrite_in;
	sequence addr_ph(logic [7:0] a, logic w);
		hsel_in && hready_in && htrans_in == erc_pkg::HTRANS_NONSEQ && hwrite_in == w
			&& haddr_in[7:0] == a;
	endsequence
	sequence soft_wr;
		addr_ph(erc_pkg::CTRL_OFFSET, 1'b1) ##1 hwdata_in[erc_pkg::CTRL_SOFTRST_BIT];
	endsequence
	////////////////////////////////////////////////////////////////
	bus_ready_a: assert property (hreadyout_out && !hresp_out)
		else $error("bus slave not ready or not okay");
	rdata_idle_a: assert property (!$past(rd_req) |-> hrdata_out == 32'h0)
		else $error("read data outside a read data phase");
	mode_read_a: assert property (addr_ph(erc_pkg::MODE_OFFSET, 1'b0) ##1 $stable(chip_mode_in)
		|-> hrdata_out == {29'h0, chip_mode_in}) else $error("mode read wrong");
	soft_pulse_a: assert property (soft_wr |-> ##[1:2] soft_reset_out)
		else $error("soft reset write gave no pulse");
	pulse_single_a: assert property (soft_reset_out |=> !soft_reset_out)
		else $error("soft reset pulse too long");
	off_modes_a: assert property ((chip_mode_in == erc_pkg::ERC_MODE_INIT
		|| chip_mode_in == erc_pkg::ERC_MODE_FAILSAFE)[*2] |=> !drive_out.enable)
		else $error("regulator on in init or fail-safe");
	hp_path_a: assert property ((chip_mode_in == erc_pkg::ERC_MODE_NORMAL)[*2] |=>
		drive_out.high_power_path == drive_out.enable && !drive_out.low_power_path)
		else $error("wrong regulator path in normal mode");
	enable_rise_a: assert property ($rose(drive_out.enable) |->
		$past(chip_mode_in) != erc_pkg::ERC_MODE_INIT
		&& $past(chip_mode_in) != erc_pkg::ERC_MODE_FAILSAFE)
		else $error("regulator switched on in an off mode");
endmodule // erc_top_assertions
bind erc_top erc_top_assertions chk_u (.clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in,
	.hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
	.chip_mode_in, .main_supply_on_in, .sense_in, .drive_out, .soft_reset_out);
`default_nettype wire

// *** sim/ext_regulator_config_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_regulator_config_control_tb;
	logic                   clk_in, rst_in, hsel_in, hwrite_in, hready_in, low, oc, uv;
	logic                   main_supply_on_in, soft_reset_out, hreadyout_out, hresp_out;
	logic [31:0]            haddr_in, hwdata_in, hrdata_out, q;
	logic [1:0]             htrans_in;
	logic [2:0]             hsize_in;
	erc_pkg::erc_mode_type  chip_mode_in;
	erc_pkg::erc_sense_type sense_in;
	erc_pkg::erc_drive_type drive_out;
	int fail_count, samples_checked, cfg, on, vs, kp, lss, hold, cf, ocf, uvf, m, v;
	erc_top DUT (.clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
		.hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .chip_mode_in,
		.main_supply_on_in, .sense_in, .drive_out, .soft_reset_out);
	erc_load_model load (.clk_in, .low_req_in(low), .oc_req_in(oc), .uv_req_in(uv),
		.drive_in(drive_out), .sense_out(sense_in));
	assign hready_in = hreadyout_out;
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic hand();
		for (int n = 0; n < 20; n++) begin
			@(posedge clk_in);
			if (hready_in === 1'b1) return;
		end
		fail_count++;
		complete_run();
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel_in <= 1'b1;
		haddr_in <= {24'h0, a};
		htrans_in <= erc_pkg::HTRANS_NONSEQ;
		hwrite_in <= w;
		hand();
		hsel_in <= 1'b0;
		htrans_in <= 2'h0;
		hwdata_in <= d;
		hand();
		q = hrdata_out;
	endtask
	// Reference regulator state: configuration, mode table and supply override
	function automatic int exp_en();
		int md;
		md = int'(chip_mode_in);
		if (low && !kp) return 0;
		if (cfg == 1) return md == 1 ? on : (md == 0 || md == 5) ? 0 : hold;
		if (cfg == 2) return md == 1 ? 1 : md == 2 ? lss : md == 4 ? int'(main_supply_on_in) : 0;
		return 0;
	endfunction
	// Settle covers the sense synchroniser plus the partner's own register
	task automatic st();
		int en;
		repeat (6) @(posedge clk_in);
		en = exp_en();
		if (oc && en && cfg == 1) ocf = 1;
		if (uv && en && cfg == 1) uvf = 1;
		chk("enable", 32'(drive_out.enable), en);
		if (en && cfg) chk("select_1v8", 32'(drive_out.select_1v8), cfg == 1 && vs);
		chk("paths", 32'({drive_out.high_power_path, drive_out.low_power_path}),
			en * 2 + int'(en && chip_mode_in != erc_pkg::ERC_MODE_NORMAL));
		bus(erc_pkg::STAT_OFFSET, 1'b0, 32'h0);
		chk("status", q & 32'hff, en + int'(cfg == 1 && vs) * 2 + int'(cfg != 0) * 4
			+ int'(cfg == 2) * 8 + ocf * 16 + uvf * 32 + cf * 64 + en * 128);
	endtask
	task automatic wr(input logic [7:0] a, input int d);
		bus(a, 1'b1, d);
		if (a == erc_pkg::CTRL_OFFSET) begin
			if (cfg == 2 && d[0]) cf = 1;
			if (cfg == 0 && d[0] && chip_mode_in == erc_pkg::ERC_MODE_NORMAL) cfg = 1;
			on = d[3] ? 0 : d[0];
			vs = d[1];
			kp = d[3] ? 0 : d[2];
			if (d[3]) lss = 0;
		end
		if (a == erc_pkg::HWCTRL_OFFSET) begin
			if (cfg == 2 && !d[0]) cf = 1;
			if (cfg == 0 && d[0] && chip_mode_in == erc_pkg::ERC_MODE_NORMAL) cfg = 2;
			lss = d[1];
		end
		if (a == erc_pkg::STAT_OFFSET) begin
			if (d[4] && !oc) ocf = 0;
			if (d[5] && !uv) uvf = 0;
			if (d[6]) cf = 0;
		end
		if (chip_mode_in == erc_pkg::ERC_MODE_NORMAL) hold = on;
		st();
	endtask
	task automatic go(input int md);
		chip_mode_in <= erc_pkg::erc_mode_type'(md);
		@(posedge clk_in);
		st();
	endtask
	task automatic por();
		rst_in <= 1'b1;
		chip_mode_in <= erc_pkg::ERC_MODE_INIT;
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		{cfg, on, vs, kp, lss, hold, cf, ocf, uvf} = '0;
		st();
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{hsel_in, hwrite_in, low, oc, uv} = '0;
		{haddr_in, hwdata_in, htrans_in} = '0;
		hsize_in = 3'h2;
		main_supply_on_in = 1'b1;
		void'($urandom(68));
		// Reset rises before the first edge so no check sees unreset state
		por();
		wr(erc_pkg::CTRL_OFFSET, 1);
		wr(erc_pkg::CTRL_OFFSET, 0);
		go(1);
		v = $urandom % 2 * 2;
		wr(erc_pkg::CTRL_OFFSET, 1 + v);
		wr(erc_pkg::HWCTRL_OFFSET, 1);
		wr(erc_pkg::CTRL_OFFSET, v);
		wr(erc_pkg::CTRL_OFFSET, 1 + v);
		low <= 1'b1;
		st();
		low <= 1'b0;
		st();
		wr(erc_pkg::CTRL_OFFSET, 5 + v);
		low <= 1'b1;
		st();
		low <= 1'b0;
		for (m = 0; m < 6; m++) go(m);
		go(1);
		oc <= 1'b1;
		st();
		wr(erc_pkg::STAT_OFFSET, 'h10);
		oc <= 1'b0;
		st();
		wr(erc_pkg::STAT_OFFSET, 'h10);
		uv <= 1'b1;
		st();
		uv <= 1'b0;
		// Let the sag leave the synchroniser, or the clear loses to the set
		st();
		wr(erc_pkg::STAT_OFFSET, 'h20);
		wr(erc_pkg::CTRL_OFFSET, 8);
		por();
		go(1);
		wr(erc_pkg::HWCTRL_OFFSET, 1);
		wr(erc_pkg::CTRL_OFFSET, 2);
		wr(erc_pkg::CTRL_OFFSET, 1);
		wr(erc_pkg::STAT_OFFSET, 'h40);
		wr(erc_pkg::HWCTRL_OFFSET, 0);
		go(2);
		bus(erc_pkg::HWCTRL_OFFSET, 1'b0, 32'h0);
		chk("ls_select", q & 32'h1, 32'h1);
		go(1);
		wr(erc_pkg::HWCTRL_OFFSET, 3);
		for (m = 2; m < 5; m++) go(m);
		main_supply_on_in <= 1'b0;
		st();
		go(5);
		go(1);
		low <= 1'b1;
		st();
		bus(erc_pkg::MODE_OFFSET, 1'b0, 32'h0);
		chk("mode", q, 32'h1);
		complete_run();
	end
endmodule // ext_regulator_config_control_tb
`default_nettype wire
